// File: i2hc_bit_engine.sv
// Bit-level engine: start, stop and nine-bit byte frames on the two wires.
// Assumes synchronised line inputs and commands only while it is idle.
`timescale 1ns/100ps
module i2hc_bit_engine import i2hc_pkg::*; (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_clear,
  input  wire logic         i_fast,
  input  wire i2hc_cmd_type i_cmd,
  input  wire logic         i_scl,
  input  wire logic         i_sda,
  output i2hc_rsp_type      o_rsp,
  output logic              o_scl_oe,
  output logic              o_sda_oe
);

  typedef enum logic [1:0] {EN_IDLE, EN_START, EN_BITS, EN_STOP} i2hc_en_type;

  i2hc_en_type state;
  i2hc_op_type op;
  logic [9:0]  tick_cnt;
  logic [1:0]  phase;
  logic [3:0]  bit_idx;
  logic [7:0]  shift;
  logic        nack;
  logic        adv;
  logic        next_scl_oe;
  logic        next_sda_oe;

  // ***************************************************
  // Quarter-period timebase
  // ***************************************************
  // Phase 1 waits for the released clock line to go high
  assign adv = (tick_cnt == 10'h000) && !(phase == 2'h1 && !i_scl);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= QTR_STD_CYC;
    end else if (i_clear || state == EN_IDLE || tick_cnt == 10'h000) begin
      tick_cnt <= (i_fast ? QTR_FAST_CYC : QTR_STD_CYC) - 10'h001;
    end else begin
      tick_cnt <= tick_cnt - 10'h001;
    end
  end

  // ***************************************************
  // Sequencing
  // ***************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state   <= EN_IDLE;
      op      <= OP_START;
      phase   <= 2'h0;
      bit_idx <= 4'h0;
      shift   <= DATA_RESET;
      nack    <= 1'b0;
      o_rsp   <= '0;
    end else if (i_clear) begin
      state   <= EN_IDLE;
      phase   <= 2'h0;
      o_rsp   <= '0;
    end else begin
      o_rsp.done <= 1'b0;
      if (state == EN_IDLE) begin
        if (i_cmd.valid) begin
          op      <= i_cmd.op;
          shift   <= i_cmd.data;
          nack    <= i_cmd.nack;
          phase   <= 2'h0;
          bit_idx <= 4'h0;
          unique case (i_cmd.op)
            OP_START: state <= EN_START;
            OP_STOP:  state <= EN_STOP;
            OP_WRITE, OP_READ: state <= EN_BITS;
          endcase
        end
      end else if (adv) begin
        phase <= phase + 2'h1;
        if (state == EN_BITS && phase == 2'h2) begin
          if (bit_idx == LAST_BIT_IDX) begin
            o_rsp.ack <= !i_sda;
          end else if (op == OP_READ) begin
            shift <= {shift[6:0], i_sda};
          end
        end
        if (phase == 2'h3) begin
          if (state == EN_BITS && bit_idx != LAST_BIT_IDX) begin
            bit_idx <= bit_idx + 4'h1;
            if (op == OP_WRITE) begin
              shift <= {shift[6:0], 1'b0};
            end
          end else begin
            state       <= EN_IDLE;
            o_rsp.done  <= 1'b1;
            o_rsp.data  <= shift;
          end
        end
      end
    end
  end

  // ***************************************************
  // Line drive, low or released only
  // ***************************************************
  always_comb begin
    next_scl_oe = o_scl_oe;
    next_sda_oe = o_sda_oe;
    unique case (state)
      EN_IDLE: begin
      end
      EN_START: begin
        next_sda_oe = phase[1];
        next_scl_oe = (phase == 2'h3) || (phase == 2'h0 && o_scl_oe);
      end
      EN_BITS: begin
        next_scl_oe = (phase == 2'h0) || (phase == 2'h3);
        if (bit_idx == LAST_BIT_IDX) begin
          next_sda_oe = (op == OP_READ) && !nack;
        end else begin
          next_sda_oe = (op == OP_WRITE) && !shift[7];
        end
      end
      EN_STOP: begin
        next_scl_oe = (phase == 2'h0);
        next_sda_oe = !phase[1];
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (i_clear) begin
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_scl_oe <= next_scl_oe;
      o_sda_oe <= next_sda_oe;
    end
  end

endmodule

// File: i2hc_host_controller.sv
// Two-wire bus host controller reached through two internal 8-bit registers.
// Assumes pull-ups on both lines and a one-cycle register read/write strobe.
`timescale 1ns/100ps
module i2hc_host_controller import i2hc_pkg::*; (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_fast_mode,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_scl,
  output logic            o_scl,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe
);

  typedef enum logic [2:0] {
    SQ_IDLE,
    SQ_START,
    SQ_ADDR,
    SQ_ADDR_TX,
    SQ_READY,
    SQ_XFER,
    SQ_STOP
  } i2hc_sq_type;

  i2hc_sq_type  sq;
  i2hc_cmd_type cmd;
  i2hc_rsp_type rsp;

  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] rst_cnt;
  logic       soft_clr;

  logic       err_flag;
  logic       ack_flag;
  logic       done_flag;
  logic       busy_flag;
  logic       last_flag;
  logic       stop_flag;
  logic       start_flag;
  logic       rd_mode;
  logic [7:0] data_byte;

  logic       ctrl_wr;
  logic       ctrl_rd;
  logic       data_wr;
  logic       data_rd;
  logic       reset_wr;
  logic       start_ok;
  logic       stop_ok;
  logic       last_ok;
  logic       dwr_ok;
  logic       drd_ok;
  logic       any_bad;
  logic       any_ok;
  logic       fin_addr;
  logic       fin_xfer;
  logic       fin_stop;

  // ***************************************************
  // Address decode
  // ***************************************************
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  assign ctrl_wr  = i_reg_wr && reg_hit(i_reg_addr, CTRL_OFS) && !soft_clr;
  assign ctrl_rd  = reg_hit(i_reg_addr, CTRL_OFS);
  assign data_wr  = i_reg_wr && reg_hit(i_reg_addr, DATA_OFS) && !soft_clr;
  assign data_rd  = i_reg_rd && reg_hit(i_reg_addr, DATA_OFS) && !soft_clr;
  assign reset_wr = ctrl_wr && i_reg_wdata[BIT_RESET];

  // ***************************************************
  // Line synchronisers
  // ***************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          pin_meta[gi] <= 1'b1;
          pin_sync[gi] <= 1'b1;
        end else begin
          pin_meta[gi] <= (gi == 0) ? i_scl : i_sda;
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // ***************************************************
  // Momentary self-reset
  // ***************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt <= 2'h0;
    end else if (reset_wr) begin
      rst_cnt <= SOFT_RST_CYC;
    end else if (rst_cnt != 2'h0) begin
      rst_cnt <= rst_cnt - 2'h1;
    end
  end

  assign soft_clr = (rst_cnt != 2'h0);

  // ***************************************************
  // Request acceptance
  // ***************************************************
  // A reset write suppresses the set bits written alongside it
  assign start_ok = ctrl_wr && !reset_wr && i_reg_wdata[BIT_START]
                    && (!busy_flag || done_flag);
  assign stop_ok  = ctrl_wr && !reset_wr && i_reg_wdata[BIT_STOP] && !start_ok
                    && done_flag && busy_flag;
  assign last_ok  = ctrl_wr && !reset_wr && i_reg_wdata[BIT_LAST]
                    && done_flag;
  assign dwr_ok   = data_wr && done_flag
                    && (sq == SQ_ADDR || (sq == SQ_READY && !rd_mode));
  assign drd_ok   = data_rd && done_flag && rd_mode
                    && (sq == SQ_READY || sq == SQ_IDLE);

  assign any_ok  = start_ok || stop_ok || dwr_ok || drd_ok;
  assign any_bad = (ctrl_wr && !reset_wr && i_reg_wdata[BIT_START] && !start_ok)
                   || (ctrl_wr && !reset_wr && i_reg_wdata[BIT_STOP] && !start_ok
                       && !stop_ok)
                   || (data_wr && !dwr_ok)
                   || (data_rd && !drd_ok);

  // ***************************************************
  // Engine commands
  // ***************************************************
  always_comb begin
    cmd       = '0;
    cmd.data  = i_reg_wdata;
    cmd.nack  = last_flag;
    cmd.valid = start_ok || stop_ok || dwr_ok || (drd_ok && sq == SQ_READY);
    if (start_ok) begin
      cmd.op = OP_START;
    end else if (stop_ok) begin
      cmd.op = OP_STOP;
    end else if (dwr_ok) begin
      cmd.op = OP_WRITE;
    end else begin
      cmd.op = OP_READ;
    end
  end

  assign fin_addr = rsp.done && sq == SQ_ADDR_TX;
  assign fin_xfer = rsp.done && sq == SQ_XFER;
  assign fin_stop = rsp.done && sq == SQ_STOP;

  i2hc_bit_engine u_engine (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_clear  (soft_clr),
    .i_fast   (i_fast_mode),
    .i_cmd    (cmd),
    .i_scl    (pin_sync[0]),
    .i_sda    (pin_sync[1]),
    .o_rsp    (rsp),
    .o_scl_oe (o_scl_oe),
    .o_sda_oe (o_sda_oe)
  );

  assign o_scl = 1'b0;
  assign o_sda = 1'b0;

  // ***************************************************
  // Transfer sequencer
  // ***************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sq <= SQ_IDLE;
    end else if (soft_clr) begin
      sq <= SQ_IDLE;
    end else if (start_ok) begin
      sq <= SQ_START;
    end else if (stop_ok) begin
      sq <= SQ_STOP;
    end else if (dwr_ok) begin
      sq <= (sq == SQ_ADDR) ? SQ_ADDR_TX : SQ_XFER;
    end else if (drd_ok && sq == SQ_READY) begin
      sq <= SQ_XFER;
    end else if (rsp.done) begin
      unique case (sq)
        SQ_START:             sq <= SQ_ADDR;
        SQ_ADDR_TX, SQ_XFER:  sq <= SQ_READY;
        SQ_STOP:              sq <= SQ_IDLE;
        default:              sq <= sq;
      endcase
    end
  end

  // ***************************************************
  // Status flags
  // ***************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_flag <= 1'b0;
    end else if (soft_clr) begin
      done_flag <= 1'b0;
    end else if (rsp.done) begin
      done_flag <= 1'b1;
    end else if (any_ok) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_flag <= 1'b0;
    end else if (soft_clr) begin
      busy_flag <= 1'b0;
    end else if (start_ok) begin
      busy_flag <= 1'b1;
    end else if (fin_stop) begin
      busy_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err_flag <= 1'b0;
    end else if (soft_clr) begin
      err_flag <= 1'b0;
    end else if (any_bad) begin
      err_flag <= 1'b1;
    end else if (any_ok) begin
      err_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_flag <= 1'b0;
    end else if (soft_clr) begin
      ack_flag <= 1'b0;
    end else if (fin_addr || (fin_xfer && !rd_mode)) begin
      ack_flag <= rsp.ack;
    end
  end

  // ***************************************************
  // Set-on-write control bits
  // ***************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      start_flag <= 1'b0;
    end else if (soft_clr) begin
      start_flag <= 1'b0;
    end else if (start_ok) begin
      start_flag <= 1'b1;
    end else if (fin_addr) begin
      start_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stop_flag <= 1'b0;
    end else if (soft_clr) begin
      stop_flag <= 1'b0;
    end else if (stop_ok) begin
      stop_flag <= 1'b1;
    end else if (fin_stop) begin
      stop_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_flag <= 1'b0;
    end else if (soft_clr) begin
      last_flag <= 1'b0;
    end else if (last_ok) begin
      last_flag <= 1'b1;
    end else if (fin_stop) begin
      last_flag <= 1'b0;
    end
  end

  // ***************************************************
  // Data byte and direction
  // ***************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_mode <= 1'b0;
    end else if (soft_clr) begin
      rd_mode <= 1'b0;
    end else if (dwr_ok && sq == SQ_ADDR) begin
      rd_mode <= i_reg_wdata[0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_byte <= DATA_RESET;
    end else if (soft_clr) begin
      data_byte <= DATA_RESET;
    end else if (dwr_ok) begin
      data_byte <= i_reg_wdata;
    end else if (fin_xfer && rd_mode) begin
      data_byte <= rsp.data;
    end
  end

  // ***************************************************
  // Register read-back
  // ***************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (ctrl_rd) begin
        o_reg_rdata <= {start_flag, stop_flag, last_flag, 1'b0,
                        busy_flag, done_flag, ack_flag, err_flag};
      end else if (reg_hit(i_reg_addr, DATA_OFS)) begin
        o_reg_rdata <= data_byte;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// File: i2hc_pkg.sv
// Shared constants and types for the two-wire bus host controller.
// Assumes a single 40 MHz system clock and an 8-bit internal register port.
package i2hc_pkg;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int         CLK_PERIOD_NS     = 25;
  localparam int         SCL_STD_PERIOD_NS = 10000;
  localparam int         FAST_FACTOR       = 4;
  localparam logic [9:0] QTR_STD_CYC  = 10'(SCL_STD_PERIOD_NS / (4 * CLK_PERIOD_NS));
  localparam logic [9:0] QTR_FAST_CYC =
    10'(SCL_STD_PERIOD_NS / (4 * FAST_FACTOR * CLK_PERIOD_NS));
  localparam logic [1:0] SOFT_RST_CYC = 2'h2;
  localparam logic [3:0] LAST_BIT_IDX = 4'h8;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h08;
  localparam logic [7:0] DATA_OFS   = 8'h0C;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int         BIT_ERR    = 0;
  localparam int         BIT_ACK    = 1;
  localparam int         BIT_DONE   = 2;
  localparam int         BIT_BUSY   = 3;
  localparam int         BIT_RESET  = 4;
  localparam int         BIT_LAST   = 5;
  localparam int         BIT_STOP   = 6;
  localparam int         BIT_START  = 7;

  // ***************************************************
  // Engine command and response
  // ***************************************************
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} i2hc_op_type;

  typedef struct packed {
    logic        valid;
    i2hc_op_type op;
    logic [7:0]  data;
    logic        nack;
  } i2hc_cmd_type;

  typedef struct packed {
    logic       done;
    logic       ack;
    logic [7:0] data;
  } i2hc_rsp_type;

endpackage

// File: i2hc_properties.sv
// Port-level checks on the two-wire bus host controller.
// Assumes one clock domain; bound to the controller at the foot of this file.
`timescale 1ns/100ps
module i2hc_properties import i2hc_pkg::*; (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_fast_mode,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_scl,
  input wire logic       o_scl,
  input wire logic       o_scl_oe,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe
);
  // **********
  // Helpers
  // **********
  logic [1:0] sr;
  logic [9:0] lowc;
  // Soft reset window, checks paused except chk_soft_release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      sr <= 2'h0;
    else if (i_reg_wr && i_reg_addr == CTRL_OFS && i_reg_wdata[BIT_RESET])
      sr <= 2'h3;
    else if (sr != 2'h0)
      sr <= sr - 2'h1;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      lowc <= 10'h000;
    else if (!o_scl_oe)
      lowc <= 10'h000;
    else if (lowc != 10'h3FF)
      lowc <= lowc + 10'h001;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst || sr != 2'h0);
  // **********
  // Assertions
  // **********
  chk_open_drain: assert property (
    o_scl == 1'b0 && o_sda == 1'b0) else $error("line data value not low");
  chk_unmapped_zero: assert property (
    i_reg_rd && i_reg_addr != CTRL_OFS && i_reg_addr != DATA_OFS |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved without read");
  chk_reset_bit_zero: assert property (
    i_reg_rd && i_reg_addr == CTRL_OFS |=> !o_reg_rdata[BIT_RESET])
    else $error("self reset bit retained");
  chk_soft_release: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_reg_wr && i_reg_addr == CTRL_OFS && i_reg_wdata[BIT_RESET] |-> ##3 !o_scl_oe && !o_sda_oe)
    else $error("lines held after self reset");
  chk_scl_low_time: assert property (
    $fell(o_scl_oe) |-> lowc >= (i_fast_mode ? QTR_FAST_CYC : QTR_STD_CYC) - 10'h001)
    else $error("clock low phase too short");
  chk_start_pull: assert property (
    $rose(o_sda_oe) && !o_scl_oe |-> ##[20:110] o_scl_oe)
    else $error("no clock pull after start");
  chk_stop_quiet: assert property (
    $fell(o_sda_oe) && !o_scl_oe |=> (!o_scl_oe && !o_sda_oe)[*8])
    else $error("lines pulled right after stop");
  chk_idle_released: assert property (
    i_reg_rd && i_reg_addr == CTRL_OFS ##1 !o_reg_rdata[BIT_BUSY] |-> !o_scl_oe && !o_sda_oe)
    else $error("lines pulled while not busy");
  cov_start: cover property ($rose(o_sda_oe) && !o_scl_oe);
  cov_stop: cover property ($fell(o_sda_oe) && !o_scl_oe);
  cov_soft: cover property (sr == 2'h3);
endmodule

bind i2hc_host_controller i2hc_properties i2hc_properties_inst (.i_clk, .i_rst, .i_fast_mode,
  .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_scl, .o_scl, .o_scl_oe,
  .i_sda, .o_sda, .o_sda_oe);

// File: i2hc_slave_model.sv
// Two-wire bus slave: fixed address, acks writes, sends 5Ah upward.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/100ps
module i2hc_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  input  wire logic  i_stretch,
  output logic       o_scl_oe = 1'b0,
  output logic       o_sda_oe = 1'b0,
  output logic [7:0] o_got = 8'h00,
  output logic       o_nacked = 1'b0
);
  // **********
  // Line protocol
  // **********
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic       rd = 1'b0;
  int         ph = 0;
  int         n = 0;
  always @(negedge i_sda)
    if (i_scl === 1'b1) begin
      ph = 1;
      n = 0;
      rd = 1'b0;
      cnt = 8'h00;
    end
  always @(posedge i_sda)
    if (i_scl === 1'b1)
      ph = 0;
  always @(posedge i_scl)
    if (ph != 0) begin
      if (n < 8)
        sh = {sh[6:0], i_sda};
      else if (rd && ph == 2 && i_sda) begin
        o_nacked = 1'b1;
        ph = 0;
      end
      n = n + 1;
    end
  always @(negedge i_scl) begin
    if (ph == 1 && n == 8) begin
      rd = sh[0];
      o_sda_oe = (sh[7:1] == ADDR);
      if (sh[7:1] != ADDR)
        ph = 0;
    end else if (ph == 2 && n == 8) begin
      if (!rd)
        o_got = sh;
      o_sda_oe = !rd;
    end else if (ph != 0 && n == 9) begin
      n = 0;
      ph = 2;
      tx = 8'h5A + cnt;
      if (rd)
        cnt = cnt + 8'h01;
      o_sda_oe = rd && !tx[7];
    end else if (ph == 2 && rd && n > 0 && n < 8)
      o_sda_oe = !tx[7 - n];
    // Slow slave holds the clock low
    if (i_stretch) begin
      o_scl_oe = 1'b1;
      #12000 o_scl_oe = 1'b0;
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench: host controller against the slave model.
// Assumes pull-ups on both lines and the slave at address SLV.
`timescale 1ns/100ps
module testbench import i2hc_pkg::*;;
  localparam logic [6:0] SLV = 7'h2A;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        fast = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        stretch = 1'b0;
  logic        took = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, got, eq[$], mq[$];
  logic        scl_oe, sda_oe, s_scl_oe, s_sda_oe, nacked;
  wire logic   scl = !(scl_oe | s_scl_oe);
  wire logic   sda = !(sda_oe | s_sda_oe);
  logic [15:0] lf = 16'hBBDA;
  int          mismatches = 0;
  int          n_checks = 0;
  int          pulses = 0;
  realtime     t0 = 0;
  realtime     t1 = 0;
  i2hc_host_controller i2hc_host_controller_inst (.i_clk(clk), .i_rst(rst),
    .i_fast_mode(fast), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe));
  i2hc_slave_model #(.ADDR(SLV)) i2hc_slave_model_inst (.i_scl(scl), .i_sda(sda),
    .i_stretch(stretch), .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe), .o_got(got),
    .o_nacked(nacked));
  always #12.5 clk = ~clk;
  always @(posedge scl) begin
    pulses++;
    t0 = t1;
    t1 = $realtime;
  end
  // **********
  // Tasks
  // **********
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_span(input int g, input int lo, input int hi);
    n_checks++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    eq.push_back(e);
    mq.push_back(m);
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic wait_done;
    int k = 0;
    do begin
      rd_reg(CTRL_OFS, 8'h00, 8'h00);
      k++;
    end while (rdata[BIT_DONE] !== 1'b1 && k < 6000);
    chk_byte(rdata, 8'h04, 8'h04);
  endtask
  task automatic start_addr(input logic [7:0] a);
    wr_reg(CTRL_OFS, 8'h80);
    // Ack bit still shows the previous frame, masked
    rd_reg(CTRL_OFS, 8'h88, 8'hFD);
    wait_done();
    rd_reg(CTRL_OFS, 8'h8C, 8'hFD);
    wr_reg(DATA_OFS, a);
    wait_done();
  endtask
  task automatic stop_bus(input logic [7:0] e);
    wr_reg(CTRL_OFS, 8'h40);
    wait_done();
    rd_reg(CTRL_OFS, e, 8'hFF);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) took <= rd;
  always @(negedge clk)
    if (took) begin
      if (mq[0] != 8'h00)
        chk_byte(rdata, eq[0], mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  // **********
  // Scenarios
  // **********
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rd_reg(CTRL_OFS, 8'h00, 8'hFF);
    rd_reg(DATA_OFS, DATA_RESET, 8'hFF);
    rd_reg(8'h10, 8'h00, 8'hFF);
    wr_reg(DATA_OFS, 8'h55);
    wr_reg(CTRL_OFS, 8'h6F);
    rd_reg(CTRL_OFS, 8'h01, 8'hFF);
    $display("test refusal finished");
    stretch = 1'b1;
    start_addr({SLV, 1'b0});
    rd_reg(CTRL_OFS, 8'h0E, 8'hFF);
    repeat (2) begin
      lf = lfsr(lf);
      wr_reg(DATA_OFS, lf[7:0]);
      wait_done();
      chk_byte(got, lf[7:0], 8'hFF);
      rd_reg(DATA_OFS, 8'h00, 8'h00);
      rd_reg(CTRL_OFS, 8'h0F, 8'hFF);
    end
    start_addr({SLV, 1'b0});
    stop_bus(8'h06);
    $display("test write finished");
    stretch = 1'b0;
    start_addr({~SLV, 1'b0});
    rd_reg(CTRL_OFS, 8'h0C, 8'hFF);
    chk_span(int'((t1 - t0) / 25.0), 4 * QTR_STD_CYC, 4 * QTR_STD_CYC + 8);
    stop_bus(8'h04);
    $display("test no answer finished");
    wr_reg(CTRL_OFS, 8'h80);
    wait_done();
    wr_reg(DATA_OFS, {SLV, 1'b0});
    wr_reg(CTRL_OFS, 8'h1F);
    @(negedge clk);
    rd_reg(CTRL_OFS, 8'h00, 8'hFF);
    $display("test self reset finished");
    fast = 1'b1;
    start_addr({SLV, 1'b1});
    pulses = 0;
    rd_reg(DATA_OFS, {SLV, 1'b1}, 8'hFF);
    wait_done();
    chk_span(pulses, 9, 9);
    chk_span(int'((t1 - t0) / 25.0), 4 * QTR_FAST_CYC, 4 * QTR_FAST_CYC + 8);
    rd_reg(DATA_OFS, 8'h5A, 8'hFF);
    wait_done();
    wr_reg(CTRL_OFS, 8'h20);
    rd_reg(DATA_OFS, 8'h5B, 8'hFF);
    wait_done();
    stop_bus(8'h06);
    rd_reg(DATA_OFS, 8'h5C, 8'hFF);
    rd_reg(CTRL_OFS, 8'h02, 8'hFB);
    chk_byte({7'h00, nacked}, 8'h01, 8'hFF);
    $display("test read finished");
    report_and_stop();
  end
endmodule
